// File: hw/igo_pkg.sv
// Package with offsets, field layouts and carriers for the input gain/offset registers
package igo_pkg;
	localparam logic [3:0] ADDR_GAIN_SELECT = 4'h7;
	localparam logic [3:0] ADDR_OFFSET_TRIM_A = 4'h8;
	localparam logic [3:0] ADDR_OFFSET_TRIM_B = 4'h9;
	localparam logic [3:0] ADDR_INTERP_RATE = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'hA;
	localparam int COARSE_LSB = 0;
	localparam int FINE_A_LSB = 3;
	localparam int FINE_B_LSB = 5;
	localparam int OFS_SIGN_BIT = 5;
	localparam logic [2:0] COARSE_UNDEFINED = 3'h7;
	localparam logic [7:0] GAIN_RESET = 8'h00;
	localparam logic [7:0] OFFSET_RESET = 8'h00;
	localparam logic [7:0] INTERP_RESET = 8'h04;
	localparam int OFS_STEP_MV = 13;
	localparam int EDGES_PER_PERIOD = 4;
	// Fine gain in tenths of a dB per code step
	localparam int FINE_STEP_CDB = 7;
	localparam int NVM_LOAD_CYCLES = 4;

	typedef struct packed {
		logic [2:0] coarse_gain_code;
		logic [1:0] fine_gain_ch_a;
		logic [1:0] fine_gain_ch_b;
		logic [5:0] offset_trim_ch_a;
		logic [5:0] offset_trim_ch_b;
		logic [7:0] interp_rate_code;
	} igo_cfg_t;

	typedef struct packed {
		logic neg;
		logic [4:0] mag;
	} igo_trim_t;
endpackage : igo_pkg

// File: hw/igo_trim_dec.sv
// Sign-magnitude offset trim decoder for one channel
`timescale 1ns/1ps
module igo_trim_dec (
	input wire logic [5:0] code_i,
	output igo_pkg::igo_trim_t trim_o,
	output logic [8:0] offset_mv_o
);
	wire zero_mag = (code_i[4:0] == 5'h00);
	assign trim_o.neg = code_i[igo_pkg::OFS_SIGN_BIT] & ~zero_mag;
	assign trim_o.mag = code_i[4:0];
	assign offset_mv_o = 9'(code_i[4:0] * igo_pkg::OFS_STEP_MV);
endmodule : igo_trim_dec

// File: hw/igo_gain_dec.sv
// Coarse and fine gain selection for the input amplifier
`timescale 1ns/1ps
module igo_gain_dec (
	input wire logic [2:0] code_i,
	input wire logic [2:0] nvm_code_i,
	input wire logic [1:0] fine_i,
	output logic [2:0] coarse_eff_o,
	output logic [4:0] fine_cdb_o
);
	assign coarse_eff_o = (code_i == igo_pkg::COARSE_UNDEFINED) ? nvm_code_i : code_i;
	assign fine_cdb_o = 5'(fine_i * igo_pkg::FINE_STEP_CDB);
endmodule : igo_gain_dec

// File: hw/igo_top.sv
// Input stage gain and offset trim configuration register bank
// How it works
// - One 3-bit coarse gain in gain_select 2:0 drives both channels.
// - Coarse codes 0 to 6 pick rising gain, halving input range each step.
// - Coarse code 7 is undefined; the stored non-volatile coarse gain is used.
// - Fine gain per channel: A in bits 4:3, B in bits 6:5.
// - Fine codes add 0, 0.7, 1.4, 2.1 dB gain.
// - Six-bit offset trim per channel at offsets 8 and 9, bits 5:0.
// - Trim is sign-magnitude, 13 mV steps; both zero codes mean none.
// - Fields load from non-volatile storage after reset, then stay read/write.
// - Resolution equals quadrature edges counted per input period.
`timescale 1ns/1ps
module igo_top (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	input wire logic [7:0] NVM_GAIN_I,
	input wire logic [5:0] NVM_OFS_A_I,
	input wire logic [5:0] NVM_OFS_B_I,
	input wire logic [7:0] NVM_INTERP_I,
	output logic LOAD_DONE_O,
	output logic [2:0] COARSE_GAIN_O,
	output logic [4:0] FINE_CDB_A_O,
	output logic [4:0] FINE_CDB_B_O,
	output logic OFS_NEG_A_O,
	output logic [4:0] OFS_MAG_A_O,
	output logic OFS_NEG_B_O,
	output logic [4:0] OFS_MAG_B_O,
	output logic [9:0] INTERP_FACTOR_Q2_O
);
	typedef enum logic [1:0] {
		ST_LOAD = 2'b01,
		ST_RUN = 2'b10
	} igo_state_t;

	igo_state_t state_r, state_nxt;
	logic [2:0] load_cnt_r;
	logic [7:0] gain_r, ofs_a_r, ofs_b_r, interp_r;
	logic [7:0] rdata_r;
	logic [2:0] coarse_out_r;
	logic [4:0] fine_a_out_r, fine_b_out_r;
	logic neg_a_r, neg_b_r;
	logic [4:0] mag_a_r, mag_b_r;
	logic [9:0] factor_r;
	logic done_r;

	wire load_end = (state_r == ST_LOAD) && (load_cnt_r == 3'(igo_pkg::NVM_LOAD_CYCLES - 1));
	wire running = (state_r == ST_RUN);
	wire wr_gain = running & WR_I & (ADDR_I == igo_pkg::ADDR_GAIN_SELECT);
	wire wr_ofs_a = running & WR_I & (ADDR_I == igo_pkg::ADDR_OFFSET_TRIM_A);
	wire wr_ofs_b = running & WR_I & (ADDR_I == igo_pkg::ADDR_OFFSET_TRIM_B);
	wire wr_interp = running & WR_I & (ADDR_I == igo_pkg::ADDR_INTERP_RATE);

	igo_pkg::igo_cfg_t cfg;
	assign cfg.coarse_gain_code = gain_r[igo_pkg::COARSE_LSB +: 3];
	assign cfg.fine_gain_ch_a = gain_r[igo_pkg::FINE_A_LSB +: 2];
	assign cfg.fine_gain_ch_b = gain_r[igo_pkg::FINE_B_LSB +: 2];
	assign cfg.offset_trim_ch_a = ofs_a_r[5:0];
	assign cfg.offset_trim_ch_b = ofs_b_r[5:0];
	assign cfg.interp_rate_code = interp_r;

	logic [2:0] coarse_eff, coarse_eff_b;
	logic [4:0] fine_cdb_a, fine_cdb_b;
	igo_pkg::igo_trim_t trim_a, trim_b;

	igo_gain_dec u_gain_a (
		.code_i(cfg.coarse_gain_code),
		.nvm_code_i(NVM_GAIN_I[2:0]),
		.fine_i(cfg.fine_gain_ch_a),
		.coarse_eff_o(coarse_eff),
		.fine_cdb_o(fine_cdb_a)
	);
	igo_gain_dec u_gain_b (
		.code_i(cfg.coarse_gain_code),
		.nvm_code_i(NVM_GAIN_I[2:0]),
		.fine_i(cfg.fine_gain_ch_b),
		.coarse_eff_o(coarse_eff_b),
		.fine_cdb_o(fine_cdb_b)
	);
	igo_trim_dec u_trim_a (
		.code_i(cfg.offset_trim_ch_a),
		.trim_o(trim_a),
		.offset_mv_o()
	);
	igo_trim_dec u_trim_b (
		.code_i(cfg.offset_trim_ch_b),
		.trim_o(trim_b),
		.offset_mv_o()
	);

	// Factor in quarter units equals resolution code; code 0 gives 256
	wire [9:0] res_edges = (interp_r == 8'h00) ? 10'h100 : {2'h0, interp_r};

	wire [7:0] rd_mux =
		(ADDR_I == igo_pkg::ADDR_GAIN_SELECT) ? {1'b0, gain_r[6:0]} :
		(ADDR_I == igo_pkg::ADDR_OFFSET_TRIM_A) ? {2'h0, ofs_a_r[5:0]} :
		(ADDR_I == igo_pkg::ADDR_OFFSET_TRIM_B) ? {2'h0, ofs_b_r[5:0]} :
		(ADDR_I == igo_pkg::ADDR_INTERP_RATE) ? interp_r :
		(ADDR_I == igo_pkg::ADDR_STATUS) ? {7'h00, running} : 8'h00;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_LOAD: begin
				if (load_end) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				state_nxt = ST_RUN;
			end
			default: begin
				state_nxt = ST_LOAD;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			state_r <= ST_LOAD;
			load_cnt_r <= 3'h0;
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_LOAD) begin
				load_cnt_r <= load_cnt_r + 3'h1;
			end
		end
	end

	// Load from storage then software access
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			gain_r <= igo_pkg::GAIN_RESET;
		end else if (load_end) begin
			gain_r <= {1'b0, NVM_GAIN_I[6:0]};
		end else if (wr_gain) begin
			gain_r <= {1'b0, WDATA_I[6:0]};
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ofs_a_r <= igo_pkg::OFFSET_RESET;
			ofs_b_r <= igo_pkg::OFFSET_RESET;
		end else if (load_end) begin
			ofs_a_r <= {2'h0, NVM_OFS_A_I};
			ofs_b_r <= {2'h0, NVM_OFS_B_I};
		end else begin
			if (wr_ofs_a) begin
				ofs_a_r <= {2'h0, WDATA_I[5:0]};
			end
			if (wr_ofs_b) begin
				ofs_b_r <= {2'h0, WDATA_I[5:0]};
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			interp_r <= igo_pkg::INTERP_RESET;
		end else if (load_end) begin
			interp_r <= NVM_INTERP_I;
		end else if (wr_interp) begin
			interp_r <= WDATA_I;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			rdata_r <= 8'h00;
		end else if (RD_I) begin
			rdata_r <= rd_mux;
		end else begin
			rdata_r <= 8'h00;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			coarse_out_r <= 3'h0;
			fine_a_out_r <= 5'h00;
			fine_b_out_r <= 5'h00;
			neg_a_r <= 1'b0;
			mag_a_r <= 5'h00;
			neg_b_r <= 1'b0;
			mag_b_r <= 5'h00;
			factor_r <= 10'h000;
			done_r <= 1'b0;
		end else begin
			coarse_out_r <= coarse_eff;
			fine_a_out_r <= fine_cdb_a;
			fine_b_out_r <= fine_cdb_b;
			neg_a_r <= trim_a.neg;
			mag_a_r <= trim_a.mag;
			neg_b_r <= trim_b.neg;
			mag_b_r <= trim_b.mag;
			factor_r <= res_edges;
			done_r <= running;
		end
	end

	assign RDATA_O = rdata_r;
	assign LOAD_DONE_O = done_r;
	assign COARSE_GAIN_O = coarse_out_r;
	assign FINE_CDB_A_O = fine_a_out_r;
	assign FINE_CDB_B_O = fine_b_out_r;
	assign OFS_NEG_A_O = neg_a_r;
	assign OFS_MAG_A_O = mag_a_r;
	assign OFS_NEG_B_O = neg_b_r;
	assign OFS_MAG_B_O = mag_b_r;
	assign INTERP_FACTOR_Q2_O = factor_r;

	// Both channels must see the same coarse setting
	// Shared coarse check
	a_coarse_shared: assert property (@(posedge CLK_I) disable iff (RST_I)
		coarse_eff == coarse_eff_b) else $error("coarse gain differs between channels");
	a_coarse_fallback: assert property (@(posedge CLK_I) disable iff (RST_I)
		(gain_r[2:0] == 3'h7) |=> (COARSE_GAIN_O == $past(NVM_GAIN_I[2:0])))
		else $error("undefined coarse code not replaced");
	a_coarse_direct: assert property (@(posedge CLK_I) disable iff (RST_I)
		(gain_r[2:0] != 3'h7) |=> (COARSE_GAIN_O == $past(gain_r[2:0])))
		else $error("coarse code not passed through");
	a_fine_step: assert property (@(posedge CLK_I) disable iff (RST_I)
		wr_gain ##1 1'b1 |=> (FINE_CDB_B_O == 5'($past(WDATA_I[6:5], 2) * 7)))
		else $error("fine gain B wrong");
	a_fine_a_field: assert property (@(posedge CLK_I) disable iff (RST_I)
		wr_gain |=> (gain_r[4:3] == $past(WDATA_I[4:3])))
		else $error("fine gain A field not stored");
	a_trim_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
		(ofs_a_r[4:0] == 5'h00) |=> !OFS_NEG_A_O) else $error("zero trim flagged negative");
	a_trim_b_write: assert property (@(posedge CLK_I) disable iff (RST_I)
		wr_ofs_b ##1 1'b1 |=> (OFS_MAG_B_O == $past(WDATA_I[4:0], 2)))
		else $error("trim B magnitude wrong");
	a_nvm_load: assert property (@(posedge CLK_I) disable iff (RST_I)
		load_end |=> (ofs_a_r[5:0] == $past(NVM_OFS_A_I)) ##1 LOAD_DONE_O)
		else $error("storage load not applied");
	a_read_back: assert property (@(posedge CLK_I) disable iff (RST_I)
		(RD_I && ADDR_I == igo_pkg::ADDR_INTERP_RATE && !WR_I) |=> (RDATA_O == $past(interp_r)))
		else $error("interp rate read back wrong");
	c_load_done: cover property (@(posedge CLK_I) disable iff (RST_I) load_end);
	c_coarse_undef: cover property (@(posedge CLK_I) disable iff (RST_I)
		wr_gain && WDATA_I[2:0] == 3'h7);
	c_neg_trim: cover property (@(posedge CLK_I) disable iff (RST_I) OFS_NEG_B_O);
	c_read_gain: cover property (@(posedge CLK_I) disable iff (RST_I)
		RD_I && ADDR_I == igo_pkg::ADDR_GAIN_SELECT);
endmodule : igo_top

// File: test/igo_top_tb_top.sv
// Self-checking testbench for the input gain and offset register bank
`timescale 1ns/1ps
module igo_top_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	// Bit 7 set on purpose: it must read back as 0
	logic [7:0] nvm_gain = 8'hAD;
	logic [5:0] nvm_ofs_a = 6'h25;
	logic [5:0] nvm_ofs_b = 6'h0A;
	logic [7:0] nvm_interp = 8'h20;
	logic load_done;
	logic [2:0] coarse;
	logic [4:0] fine_a;
	logic [4:0] fine_b;
	logic neg_a;
	logic neg_b;
	logic [4:0] mag_a;
	logic [4:0] mag_b;
	logic [9:0] factor;
	int fails = 0;
	int num_checks = 0;

	always #2 clk = ~clk;

	igo_top i_dut (
		.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RDATA_O(rdata), .NVM_GAIN_I(nvm_gain), .NVM_OFS_A_I(nvm_ofs_a),
		.NVM_OFS_B_I(nvm_ofs_b), .NVM_INTERP_I(nvm_interp), .LOAD_DONE_O(load_done),
		.COARSE_GAIN_O(coarse), .FINE_CDB_A_O(fine_a), .FINE_CDB_B_O(fine_b),
		.OFS_NEG_A_O(neg_a), .OFS_MAG_A_O(mag_a), .OFS_NEG_B_O(neg_b),
		.OFS_MAG_B_O(mag_b), .INTERP_FACTOR_Q2_O(factor)
	);

	task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict

	// Outputs are sampled two edges after the write edge
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : reg_write

	task automatic read_check(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata, exp, "read data");
	endtask : read_check

	// A write in mid-load must be dropped
	task automatic do_reset(input bit poke);
		int n;
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		if (poke) begin
			@(posedge clk);
			wr <= 1'b1;
			addr <= igo_pkg::ADDR_GAIN_SELECT;
			wdata <= 8'h11;
			@(posedge clk);
			wr <= 1'b0;
		end
		n = 0;
		while (load_done !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 20) begin
			fails++;
			$display("ERROR at %0t: storage load never finished", $time);
			print_verdict();
		end
	endtask : do_reset

	task automatic sc_load();
		read_check(igo_pkg::ADDR_GAIN_SELECT, 8'h2D);
		read_check(igo_pkg::ADDR_OFFSET_TRIM_A, 8'h25);
		read_check(igo_pkg::ADDR_OFFSET_TRIM_B, 8'h0A);
		read_check(igo_pkg::ADDR_INTERP_RATE, 8'h20);
		read_check(igo_pkg::ADDR_STATUS, 8'h01);
		read_check(4'h3, 8'h00);
		check(coarse, 3'h5, "coarse from storage");
		check(fine_a, 5'd7, "fine A from storage");
		check(neg_a, 1'b1, "sign A from storage");
		check(mag_b, 5'd10, "magnitude B from storage");
	endtask : sc_load

	// Every coarse and fine code, A and B fine codes differ
	task automatic sc_gain();
		logic [7:0] d;
		for (int i = 0; i < 8; i++) begin
			d = {1'b1, ~i[1:0], i[1:0], i[2:0]};
			reg_write(igo_pkg::ADDR_GAIN_SELECT, d);
			check(coarse, (i == 7) ? nvm_gain[2:0] : i[2:0], "coarse gain");
			check(fine_a, i[1:0] * 5'd7, "fine gain A");
			check(fine_b, {3'h0, ~i[1:0]} * 5'd7, "fine gain B");
			read_check(igo_pkg::ADDR_GAIN_SELECT, d & 8'h7F);
		end
		reg_write(4'h3, 8'h00);
		read_check(igo_pkg::ADDR_GAIN_SELECT, d & 8'h7F);
	endtask : sc_gain

	task automatic sc_trim();
		logic [5:0] codes [6] = '{6'h3F, 6'h20, 6'h00, 6'h01, 6'h21, 6'h1F};
		logic [5:0] b;
		foreach (codes[k]) begin
			b = codes[k] ^ 6'h20;
			reg_write(igo_pkg::ADDR_OFFSET_TRIM_A, {2'b11, codes[k]});
			reg_write(igo_pkg::ADDR_OFFSET_TRIM_B, {2'b10, b});
			check(neg_a, codes[k][5] && codes[k][4:0] != 5'h00, "sign A");
			check(mag_a, codes[k][4:0], "magnitude A");
			check(neg_b, b[5] && b[4:0] != 5'h00, "sign B");
			check(mag_b, b[4:0], "magnitude B");
			read_check(igo_pkg::ADDR_OFFSET_TRIM_A, {2'b00, codes[k]});
			read_check(igo_pkg::ADDR_OFFSET_TRIM_B, {2'b00, b});
		end
	endtask : sc_trim

	task automatic sc_interp();
		logic [7:0] codes [4] = '{8'h00, 8'h01, 8'h20, 8'hFF};
		foreach (codes[k]) begin
			reg_write(igo_pkg::ADDR_INTERP_RATE, codes[k]);
			check(factor, (codes[k] == 8'h00) ? 10'd256 : {2'b00, codes[k]}, "edges");
		end
	endtask : sc_interp

	initial begin
		do_reset(1'b0);
		sc_load();
		sc_gain();
		sc_trim();
		sc_interp();
		do_reset(1'b1);
		read_check(igo_pkg::ADDR_GAIN_SELECT, 8'h2D);
		print_verdict();
	end
endmodule : igo_top_tb_top
